// ### rtl/iox_top.sv
// serial-controlled expander driving eight push-pull output ports
// assumes an open-drain SDA wire resolved outside, SCL from the bus master,
// and port sense inputs that reflect the real pin levels
`include "iox_consts.svh"
`timescale 1ns/1ps
module iox_top
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   input wire logic i_if_reset_n,
   input wire logic i_low_address_select,
   input wire logic i_high_address_select,
   input wire logic [7:0] i_port_sense,
   output logic [7:0] o_output_ports,
   output logic o_standby
);
   import iox_pkg::*;

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] sel_code(input iox_sel_t kind, input logic is_high);
      logic [1:0] code;
      code = `IOX_LO_GND;
      if (is_high) begin
         case (kind)
            sel_scl: code = `IOX_HI_SCL;
            sel_sda: code = `IOX_HI_SDA;
            sel_gnd: code = `IOX_HI_GND;
            default: code = `IOX_HI_SUP;
         endcase
      end else begin
         case (kind)
            sel_gnd: code = `IOX_LO_GND;
            sel_sup: code = `IOX_LO_SUP;
            sel_scl: code = `IOX_LO_SCL;
            default: code = `IOX_LO_SDA;
         endcase
      end
      return code;
   endfunction : sel_code

   function automatic logic sel_level(input iox_sel_t kind);
      return (kind != sel_gnd);
   endfunction : sel_level

   // ----------------------------------------------------------------
   // link domain: data bit taken on the SCL rising edge itself
   // ----------------------------------------------------------------
   // the bit stays put until the next rising edge, at least a full SCL
   // period, so the main domain reads it after seeing the synced rise
   logic lk_bit;

   always_ff @(posedge i_scl) begin
      lk_bit <= i_sda;
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // bus lines and select pins share one synchroniser so their skew matches
   logic [4:0] pins_s;
   logic [7:0] sense_s;
   logic scl_s;
   logic sda_s;
   logic lo_sel_s;
   logic hi_sel_s;
   logic ifr_n_s;

   iox_sync #(.W(5), .RST_VAL(`IOX_PIN_SYNC_RST)) u_sync_pins (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_async({i_if_reset_n, i_high_address_select, i_low_address_select, i_scl, i_sda}),
      .o_sync(pins_s)
   );

   iox_sync #(.W(8), .RST_VAL(`IOX_PORT_SYNC_RST)) u_sync_sense (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_async(i_port_sense),
      .o_sync(sense_s)
   );

   assign sda_s = pins_s[0];
   assign scl_s = pins_s[1];
   assign lo_sel_s = pins_s[2];
   assign hi_sel_s = pins_s[3];
   assign ifr_n_s = pins_s[4];

   // ----------------------------------------------------------------
   // bus condition detection
   // ----------------------------------------------------------------
   logic scl_d;
   logic sda_d;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;
   logic in_frame;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;

   // frames on the bus, whoever they address
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         in_frame <= 1'b0;
      end else if (start_det) begin
         in_frame <= 1'b1;
      end else if (stop_det) begin
         in_frame <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // address select classification
   // ----------------------------------------------------------------
   iox_sel_t lo_kind;
   iox_sel_t hi_kind;
   logic [6:0] own_addr;

   iox_selpin u_sel_low (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_clear(start_det),
      .i_track(in_frame),
      .i_pin(lo_sel_s),
      .i_scl(scl_s),
      .i_sda(sda_s),
      .o_kind(lo_kind)
   );

   iox_selpin u_sel_high (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_clear(start_det),
      .i_track(in_frame),
      .i_pin(hi_sel_s),
      .i_scl(scl_s),
      .i_sda(sda_s),
      .o_kind(hi_kind)
   );

   // fixed prefix, then high pin bits, then low pin bits
   assign own_addr = {`IOX_ADDR_PREFIX, sel_code(hi_kind, 1'b1),
                      sel_code(lo_kind, 1'b0)};

   // ----------------------------------------------------------------
   // byte sequencer
   // ----------------------------------------------------------------
   iox_state_t state;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic rw;
   logic master_ack;
   logic addr_hit;
   logic byte_done;

   assign addr_hit = (shreg[7:1] == own_addr);
   assign byte_done = (bitcnt == `IOX_BYTE_BITS);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state <= st_idle;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         rw <= 1'b0;
         master_ack <= 1'b0;
      end else if (!ifr_n_s || stop_det) begin
         state <= st_idle;
         bitcnt <= 4'h0;
      end else if (start_det) begin
         state <= st_addr;
         bitcnt <= 4'h0;
      end else begin
         case (state)
            st_addr: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], lk_bit};
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall && byte_done) begin
                  if (addr_hit) begin
                     state <= st_addr_ack;
                     rw <= shreg[0];
                  end else begin
                     state <= st_skip;
                  end
               end
            end
            st_addr_ack, st_wr_ack: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  state <= (state == st_addr_ack && rw) ? st_rd_data : st_wr_data;
               end
            end
            st_wr_data: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], lk_bit};
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall && byte_done) begin
                  state <= st_wr_ack;
               end
            end
            st_rd_data: begin
               if (scl_rise) begin
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall && byte_done) begin
                  state <= st_rd_ack;
               end
            end
            st_rd_ack: begin
               if (scl_rise) begin
                  master_ack <= ~lk_bit;
               end else if (scl_fall) begin
                  bitcnt <= 4'h0;
                  state <= master_ack ? st_rd_data : st_skip;
               end
            end
            st_idle, st_skip: begin
               state <= state;
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // port readback sampling
   // ----------------------------------------------------------------
   // taken from the sensed pins, so a loaded or shorted port shows as it is
   logic [7:0] rd_sample;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         rd_sample <= 8'h00;
      end else if (scl_rise && (state == st_addr_ack || state == st_rd_ack)) begin
         rd_sample <= sense_s;
      end
   end

   // ----------------------------------------------------------------
   // SDA drive, open drain: oe_n low pulls the line low
   // ----------------------------------------------------------------
   logic send_more;
   assign send_more = (state == st_addr_ack) ? rw : (state == st_rd_ack) && master_ack;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_sda_out <= `IOX_SDA_LOW;
         o_sda_oe_n <= 1'b1;
      end else if (!ifr_n_s || stop_det || start_det) begin
         o_sda_oe_n <= 1'b1;
      end else begin
         case (state)
            st_addr: begin
               if (scl_fall && byte_done) begin
                  o_sda_oe_n <= ~addr_hit;
               end
            end
            st_addr_ack, st_wr_ack, st_rd_ack: begin
               if (scl_fall) begin
                  o_sda_oe_n <= send_more ? rd_sample[`IOX_LAST_IDX] : 1'b1;
               end
            end
            st_wr_data: begin
               if (scl_fall && byte_done) begin
                  o_sda_oe_n <= 1'b0;
               end
            end
            st_rd_data: begin
               if (scl_fall) begin
                  o_sda_oe_n <= byte_done ? 1'b1 : rd_sample[3'(`IOX_LAST_BIT - bitcnt)];
               end
            end
            default: begin
               o_sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // output port register
   // ----------------------------------------------------------------
   // defaults are caught once the select pins have passed the synchroniser
   // and classifier; the interface reset only blocks writes here and never clears this register
   logic [1:0] por_cnt;
   logic por_done;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         por_cnt <= 2'h0;
         por_done <= 1'b0;
         o_output_ports <= 8'h00;
      end else if (!por_done) begin
         if (por_cnt == `IOX_SETTLE_CYCLES) begin
            por_done <= 1'b1;
            o_output_ports <= {{4{sel_level(hi_kind)}}, {4{sel_level(lo_kind)}}};
         end else begin
            por_cnt <= por_cnt + 2'h1;
         end
      end else if (ifr_n_s && !stop_det && !start_det && state == st_wr_data && scl_rise
                   && bitcnt == `IOX_LAST_BIT) begin
         o_output_ports <= {shreg[6:0], lk_bit};
      end
   end

   // ----------------------------------------------------------------
   // standby indication
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_standby <= 1'b1;
      end else begin
         o_standby <= (state == st_idle);
      end
   end

endmodule : iox_top

// ### rtl/iox_consts.svh
// Function
// - answer only addresses with prefix 101
// - map select pins onto four address bits
// - re-decode select pins on every transmission
// - bus-tied select pins read high before traffic
// - low pin sets ports 3..0, high 7..4
// - high, SDA or SCL gives high default
// - interface reset aborts transfer, returns idle
// - interface reset leaves output ports alone
// - reads return sensed pin levels
// - idle interface means standby
// - each byte updates all eight ports together
// - bit after address selects read or write
// - resample ports each acknowledge on reads
// - acknowledge and apply every written byte
//
// constants of the push-pull output expander
// assumes it is included by bare name from rtl/
`ifndef IOX_CONSTS_SVH
`define IOX_CONSTS_SVH

`define IOX_ADDR_PREFIX 3'h5
`define IOX_BYTE_BITS 4'h8
`define IOX_LAST_BIT 4'h7
`define IOX_LAST_IDX 3'h7
`define IOX_SETTLE_CYCLES 2'h3
`define IOX_SDA_LOW 1'h0
`define IOX_PIN_SYNC_RST 5'h1f
`define IOX_PORT_SYNC_RST 8'h00
// high select pin address codes
`define IOX_HI_SCL 2'h0
`define IOX_HI_SDA 2'h1
`define IOX_HI_GND 2'h2
`define IOX_HI_SUP 2'h3
// low select pin address codes
`define IOX_LO_GND 2'h0
`define IOX_LO_SUP 2'h1
`define IOX_LO_SCL 2'h2
`define IOX_LO_SDA 2'h3

`endif

// ### rtl/iox_pkg.sv
// types of the push-pull output expander
// assumes nothing beyond a SystemVerilog compiler
package iox_pkg;

   // what an address select pin was found tied to
   typedef enum logic [1:0] {
      sel_gnd,
      sel_sup,
      sel_scl,
      sel_sda
   } iox_sel_t;

   // serial interface byte sequencer
   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_addr_ack,
      st_wr_data,
      st_wr_ack,
      st_rd_data,
      st_rd_ack,
      st_skip
   } iox_state_t;

endpackage : iox_pkg

// ### rtl/iox_sync.sv
// two-flop synchroniser, one chain per bit
// assumes inputs are asynchronous levels, held for several clocks
`timescale 1ns/1ps
module iox_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta;
         always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
               meta <= RST_VAL[g];
               o_sync[g] <= RST_VAL[g];
            end else begin
               meta <= i_async[g];
               o_sync[g] <= meta;
            end
         end
      end
   endgenerate
endmodule : iox_sync

// ### rtl/iox_selpin.sv
// classifies one address select pin as ground, supply, SCL or SDA
// assumes pin, scl and sda arrive through equal synchroniser depth
`timescale 1ns/1ps
module iox_selpin
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_clear,
   input wire logic i_track,
   input wire logic i_pin,
   input wire logic i_scl,
   input wire logic i_sda,
   output iox_pkg::iox_sel_t o_kind
);
   import iox_pkg::*;
   logic seen;
   logic diff_scl;
   logic diff_sda;

   // any mismatch against a bus line rules that line out for this frame
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         seen <= 1'b0;
         diff_scl <= 1'b0;
         diff_sda <= 1'b0;
      end else if (i_clear) begin
         seen <= 1'b1;
         diff_scl <= 1'b0;
         diff_sda <= 1'b0;
      end else if (i_track) begin
         diff_scl <= diff_scl | (i_pin != i_scl);
         diff_sda <= diff_sda | (i_pin != i_sda);
      end
   end

   // before any traffic the bus idles high, so a bus-tied pin reads as supply
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_kind <= sel_gnd;
      end else if (!seen) begin
         o_kind <= i_pin ? sel_sup : sel_gnd;
      end else if (!diff_scl) begin
         o_kind <= sel_scl;
      end else if (!diff_sda) begin
         o_kind <= sel_sda;
      end else begin
         o_kind <= i_pin ? sel_sup : sel_gnd;
      end
   end
endmodule : iox_selpin

// ### tb/iox_i2c_master.sv
// serial bus master model: drives the clock and data lines of the expander
// assumes the bench resolves SDA as an open-drain wire with a pull-up
`timescale 1ns/1ps
module iox_i2c_master (
   output logic o_scl,
   output logic o_sda,
   input wire logic i_sda
);
   logic lclk = 1'b0;

   // link clock runs at 15 ns, offset so its edges never meet the system clock
   initial begin
      o_scl = 1'b1; // both lines idle high at power-up
      o_sda = 1'b1;
      #1.3;
      forever #7.5 lclk = ~lclk;
   end

   task automatic steps(input int n);
      repeat (n) @(posedge lclk);
   endtask : steps

   task automatic start;
      o_sda = 1'b1;
      o_scl = 1'b1;
      steps(2);
      o_sda = 1'b0;
      steps(3);
      o_scl = 1'b0;
      steps(1);
   endtask : start

   task automatic stop;
      o_sda = 1'b0;
      steps(2);
      o_scl = 1'b1;
      steps(3);
      o_sda = 1'b1;
      steps(3);
   endtask : stop

   // low time of three steps leaves the device room to turn SDA round
   task automatic put_bit(input logic b);
      o_sda = b;
      steps(2);
      o_scl = 1'b1;
      steps(3);
      o_scl = 1'b0;
      steps(1);
   endtask : put_bit

   task automatic get_bit(output logic b);
      o_sda = 1'b1;
      steps(2);
      o_scl = 1'b1;
      steps(2);
      b = i_sda;
      steps(1);
      o_scl = 1'b0;
      steps(1);
   endtask : get_bit

   task automatic put_byte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i]); // msb first, direction in bit 0
      end
      get_bit(ack);
   endtask : put_byte

   task automatic get_byte(output logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         get_bit(v[i]);
      end
   endtask : get_byte
endmodule : iox_i2c_master

// ### tb/iox_top_chk.sv
// concurrent checks on the ports of the output expander
// assumes one system clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module iox_top_chk (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   input wire logic i_if_reset_n,
   input wire logic [7:0] o_output_ports,
   input wire logic o_standby
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   // the pin passes two sync flops, so give it a few cycles to bite
   sequence if_rst_held;
      !i_if_reset_n [*5];
   endsequence
   sequence if_rst_long;
      if_rst_held ##1 !i_if_reset_n [*2];
   endsequence

   sda_out_zero_a:
      assert property (o_sda_out == 1'b0) else $error("sda driven high");
   oe_fall_low_a:
      assert property ($fell(o_sda_oe_n) |-> !i_scl) else $error("sda pulled while scl high");
   busy_standby_a:
      assert property (!o_sda_oe_n |-> !o_standby) else $error("standby while driving sda");
   standby_start_a:
      assert property ($fell(o_standby) |-> !i_sda) else $error("wake without start");
   ports_scl_a:
      assert property ($changed(o_output_ports) |-> i_scl) else $error("ports moved with scl low");
   ifrst_ports_a:
      assert property (if_rst_held |=> $stable(o_output_ports)) else $error("ports moved in reset");
   ifrst_release_a:
      assert property (if_rst_held |-> o_sda_oe_n) else $error("sda held in interface reset");
   ifrst_idle_a:
      assert property (if_rst_long |-> o_standby) else $error("not idle in interface reset");
   idle_ports_a:
      assert property (o_standby [*8] |=> $stable(o_output_ports)) else $error("ports moved idle");
   powerup_hold_a:
      assert property ($rose(i_rst_n) |-> (o_output_ports == 8'h00) [*2])
         else $error("ports loaded too early");
endmodule : iox_top_chk

bind iox_top iox_top_chk iox_top_chk_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(i_scl),
   .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_if_reset_n(i_if_reset_n),
   .o_output_ports(o_output_ports), .o_standby(o_standby));

// ### tb/iox_top_test.sv
// self-checking bench of the push-pull output expander
// assumes the design, its bound checker and the master model are compiled first
`timescale 1ns/1ps
module iox_top_test;
   import iox_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic if_rst_n = 1'b1;
   logic [7:0] force_mask = 8'h00;
   iox_sel_t hi_k = sel_sup;
   iox_sel_t lo_k = sel_sup;
   logic scl, m_sda, sda, sda_out, sda_oe_n, standby, ack;
   logic [7:0] ports, r, d, last;
   logic [6:0] a;
   logic [31:0] seed = 32'hd147;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   always #2.5 mclk = ~mclk;
   assign sda = m_sda & (sda_oe_n | sda_out);

   function automatic logic pin_of(iox_sel_t k, logic c, logic s);
      return (k == sel_gnd) ? 1'b0 : (k == sel_sup) ? 1'b1 : (k == sel_scl) ? c : s;
   endfunction : pin_of
   function automatic logic [6:0] addr_of(iox_sel_t h, iox_sel_t l);
      return {3'h5, 2'(h) ^ 2'h2, 2'(l)};
   endfunction : addr_of
   function automatic logic [7:0] dflt(iox_sel_t h, iox_sel_t l);
      return {{4{h != sel_gnd}}, {4{l != sel_gnd}}};
   endfunction : dflt
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   iox_top iox_top_i (.i_mclk(mclk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_if_reset_n(if_rst_n),
      .i_low_address_select(pin_of(lo_k, scl, sda)),
      .i_high_address_select(pin_of(hi_k, scl, sda)),
      .i_port_sense(ports ^ force_mask), .o_output_ports(ports), .o_standby(standby));
   iox_i2c_master iox_i2c_master_i (.o_scl(scl), .o_sda(m_sda), .i_sda(sda));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic send(input logic [7:0] b, input logic exp_ack);
      iox_i2c_master_i.put_byte(b, ack);
      check(ack, exp_ack);
   endtask : send
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   // a hung handshake ends the run well past the expected length
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         end_of_test();
      end
   end

   // -------------------------------------------------
   // every select combination, reset on even ones only
   // -------------------------------------------------
   initial begin
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      for (int k = 0; k < 16; k++) begin
         @(negedge mclk);
         hi_k = iox_sel_t'(k[3:2]);
         lo_k = iox_sel_t'(k[1:0]);
         a = addr_of(hi_k, lo_k);
         if (k[0] == 1'b0) begin
            rst_n = 1'b0;
            repeat (6) @(negedge mclk);
            rst_n = 1'b1;
            repeat (10) @(negedge mclk);
            check(ports, dflt(hi_k, lo_k));
         end else begin
            check(ports, last);
         end
         seed = lfsr(seed);
         d = seed[7:0];
         iox_i2c_master_i.start();
         send({a, 1'b0}, 1'b0);
         send(d, 1'b0);
         check(ports, d);
         check(standby, 1'b0);
         send(~d, 1'b0);
         check(ports, ~d);
         iox_i2c_master_i.stop();
         last = ~d;
         iox_i2c_master_i.start();
         send({a ^ (k[0] ? 7'h40 : 7'h01), 1'b0}, 1'b1);
         send(~last, 1'b1);
         iox_i2c_master_i.stop();
         check(ports, last);
         @(negedge mclk);
         force_mask = seed[15:8];
         iox_i2c_master_i.start();
         send({a, 1'b1}, 1'b0);
         iox_i2c_master_i.get_byte(r);
         check(r, last ^ force_mask);
         @(negedge mclk);
         force_mask = seed[23:16];
         iox_i2c_master_i.put_bit(1'b0);
         iox_i2c_master_i.get_byte(r);
         check(r, last ^ force_mask);
         iox_i2c_master_i.put_bit(1'b1);
         iox_i2c_master_i.stop();
         check(standby, 1'b1);
         @(negedge mclk);
         force_mask = 8'h00;
      end
      // interface reset in the middle of a write
      iox_i2c_master_i.start();
      send({a, 1'b0}, 1'b0);
      @(negedge mclk);
      if_rst_n = 1'b0;
      send(~last, 1'b1);
      check(ports, last);
      check(standby, 1'b1);
      @(negedge mclk);
      if_rst_n = 1'b1;
      iox_i2c_master_i.stop();
      iox_i2c_master_i.start();
      send({a, 1'b0}, 1'b0);
      send(~last, 1'b0);
      check(ports, ~last);
      iox_i2c_master_i.stop();
      end_of_test();
   end
endmodule : iox_top_test
